/* File: inc/lmc_defs.svh */
// Constants of the macrocell and I/O cell block: sizes, bus offsets,
// reset values and timing counts.
// Assumes a single 125 MHz clock and a 32-bit classic Wishbone slave.
`ifndef LMC_DEFS_SVH
`define LMC_DEFS_SVH

`define LMC_NMC            4
`define LMC_NPT            5
`define LMC_NOE            6
`define LMC_NGCLK          2
`define LMC_NARR           12
`define LMC_NSYNC          7
`define LMC_MAX_PTERMS     32

`define LMC_ADR_GCTRL      8'h00
`define LMC_ADR_OESEL      8'h04
`define LMC_ADR_STATUS     8'h08
`define LMC_ADR_MCCFG      8'h40
`define LMC_ADR_PTERM      8'h80

`define LMC_GCTRL_RST      32'h0000_0000
`define LMC_OESEL_RST      32'h0000_0000
`define LMC_MCCFG_RST      32'h0000_0700
`define LMC_PTERM_RST      32'h0700_0000

`define LMC_GCTRL_WMASK    32'h0000_0003
`define LMC_OESEL_WMASK    32'h0003_ffff
`define LMC_MCCFG_WMASK    32'h0000_3fff
`define LMC_PTERM_WMASK    32'h07ff_ffff

`define LMC_OE_OFF         3'h6
`define LMC_OE_ON          3'h7

`define LMC_CLK_PERIOD_NS  8
`define LMC_T_LPA_NS       10
`define LMC_LPA_CYC        ((`LMC_T_LPA_NS + `LMC_CLK_PERIOD_NS - 1) / `LMC_CLK_PERIOD_NS)

`endif

/* File: inc/lmc_pkg.sv */
// Types of the macrocell and I/O cell block.
// Assumes lmc_defs.svh is on the include path.
`include "lmc_defs.svh"

package lmc_pkg;

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} lmc_ff_t;

  typedef enum logic [2:0] {PT_OR, PT_CLR, PT_PRE, PT_CLK, PT_EN, PT_SEXP, PT_KR, PT_OFF} lmc_role_t;

  typedef struct packed {
    logic [17:0] rsvd;
    logic        lend;
    logic        borrow;
    logic        odrain;
    logic        hspeed;
    logic [2:0]  oesel;
    logic        gsel;
    logic        clk_pt;
    logic        fast_in;
    logic        bypass;
    logic        xor_pol;
    lmc_ff_t     ff;
  } lmc_mccfg_t;

  typedef struct packed {
    logic [4:0]              rsvd;
    lmc_role_t               role;
    logic [`LMC_NARR-1:0]    cmask;
    logic [`LMC_NARR-1:0]    tmask;
  } lmc_pterm_t;

  typedef struct packed {
    logic       sum;
    logic [5:0] cnt;
  } lmc_par_t;

  typedef struct packed {
    logic [`LMC_LPA_CYC-1:0][`LMC_NPT-1:0] pipe;
    logic                                  ckprev;
    logic                                  q;
  } lmc_mc_state_t;

  typedef struct packed {
    logic                                    ack;
    logic [31:0]                             rdat;
    logic [`LMC_NSYNC-1:0]                   s1;
    logic [`LMC_NSYNC-1:0]                   s2;
    logic [`LMC_NSYNC-1:0]                   s3;
    logic [`LMC_NSYNC-1:0]                   filt;
    logic [`LMC_NGCLK-1:0]                   gprev;
    logic [`LMC_NARR-1:0]                    arr;
    logic [`LMC_NGCLK-1:0]                   ginv;
    logic [17:0]                             oesel;
    lmc_mccfg_t [`LMC_NMC-1:0]               mc;
    lmc_pterm_t [`LMC_NMC-1:0][`LMC_NPT-1:0] pt;
    logic [`LMC_NMC-1:0]                     pin_o;
    logic [`LMC_NMC-1:0]                     pin_oe;
    logic [`LMC_NMC-1:0]                     pin_pu;
  } lmc_state_t;

endpackage

/* File: rtl/lmc_macrocell.sv */
// One macrocell: product terms, expander chain, selectable register.
// Assumes array inputs already registered by the parent, so no loop forms.
`timescale 1ns/10ps
`include "lmc_defs.svh"

module lmc_macrocell (
  // Clock, reset, enable
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                ce_i,
  // Configuration
  input  wire lmc_pkg::lmc_mccfg_t                 cfg_i,
  input  wire lmc_pkg::lmc_pterm_t [`LMC_NPT-1:0]  pt_i,
  // Array and clocking
  input  wire logic [`LMC_NARR-1:0]                arr_i,
  input  wire logic [`LMC_NGCLK-1:0]               gedge_i,
  input  wire logic                                fast_d_i,
  input  wire lmc_pkg::lmc_par_t                   par_i,
  // Results
  output logic                                     out_o,
  output logic                                     q_o,
  output logic                                     sexp_o,
  output lmc_pkg::lmc_par_t                        par_o
);

  lmc_pkg::lmc_mc_state_t r;
  lmc_pkg::lmc_mc_state_t n;
  logic [`LMC_NPT-1:0]    pt_raw;
  logic [`LMC_NPT-1:0]    ptv;
  logic [`LMC_NPT-1:0]    is_or;
  logic [`LMC_NPT-1:0]    is_clr;
  logic [`LMC_NPT-1:0]    is_pre;
  logic [`LMC_NPT-1:0]    is_clk;
  logic [`LMC_NPT-1:0]    is_en;
  logic [`LMC_NPT-1:0]    is_sexp;
  logic [`LMC_NPT-1:0]    is_kr;
  logic [2:0]             own_cnt;
  logic [6:0]             tot_cnt;
  logic                   take;
  logic                   sum;
  logic                   xr;
  logic                   d_in;
  logic                   kdat;
  logic                   en;
  logic                   ptclk;
  logic                   evt;
  logic                   nq;

  always_comb begin
    n = r;
    own_cnt = 3'h0;
    for (int k = 0; k < `LMC_NPT; k++) begin
      // Empty masks give a term that is always true
      pt_raw[k] = (&(~pt_i[k].tmask | arr_i)) & (&(~pt_i[k].cmask | ~arr_i));
      is_or[k] = pt_i[k].role == lmc_pkg::PT_OR;
      is_clr[k] = pt_i[k].role == lmc_pkg::PT_CLR;
      is_pre[k] = pt_i[k].role == lmc_pkg::PT_PRE;
      is_clk[k] = pt_i[k].role == lmc_pkg::PT_CLK;
      is_en[k] = pt_i[k].role == lmc_pkg::PT_EN;
      is_sexp[k] = pt_i[k].role == lmc_pkg::PT_SEXP;
      is_kr[k] = pt_i[k].role == lmc_pkg::PT_KR;
      own_cnt = own_cnt + {2'h0, is_or[k]};
    end
    // Low-power cells see every term a fixed number of cycles late
    n.pipe[0] = pt_raw;
    for (int j = 1; j < `LMC_LPA_CYC; j++) begin
      n.pipe[j] = r.pipe[j-1];
    end
    ptv = cfg_i.hspeed ? pt_raw : r.pipe[`LMC_LPA_CYC-1];
    tot_cnt = 7'(par_i.cnt) + 7'(own_cnt);
    take = cfg_i.borrow & (tot_cnt <= 7'(`LMC_MAX_PTERMS));
    if (cfg_i.lend) begin
      // Lent terms go down the chain and leave this cell's own sum empty
      par_o.sum = (|(ptv & is_or)) | (take & par_i.sum);
      par_o.cnt = take ? 6'(tot_cnt) : 6'(own_cnt);
      sum = 1'b0;
    end else begin
      par_o = '0;
      sum = (|(ptv & is_or)) | (take & par_i.sum);
    end
    xr = sum ^ cfg_i.xor_pol;
    kdat = |(ptv & is_kr);
    en = ~(|is_en) | (|(ptv & is_en));
    ptclk = |(ptv & is_clk);
    n.ckprev = ptclk;
    evt = cfg_i.clk_pt ? (ptclk & ~r.ckprev) : gedge_i[cfg_i.gsel];
    d_in = cfg_i.fast_in ? fast_d_i : xr;
    unique case (cfg_i.ff)
      lmc_pkg::FF_D:  nq = d_in;
      lmc_pkg::FF_T:  nq = r.q ^ d_in;
      lmc_pkg::FF_JK: nq = (d_in & ~r.q) | (~kdat & r.q);
      lmc_pkg::FF_SR: nq = d_in | (~kdat & r.q);
    endcase
    // Clear beats preset; both ignore edge and enable
    if (|(ptv & is_clr)) begin
      n.q = 1'b0;
    end else if (|(ptv & is_pre)) begin
      n.q = 1'b1;
    end else if (evt & en) begin
      n.q = nq;
    end
    out_o = cfg_i.bypass ? xr : r.q;
    q_o = r.q;
    sexp_o = ~(|(ptv & is_sexp));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

endmodule

/* File: rtl/lmc_top.sv */
// Logic block of four macrocells, each with an I/O cell, behind Wishbone.
// Assumes pins and global clocks are asynchronous to clk_i.
`timescale 1ns/10ps
`include "lmc_defs.svh"

module lmc_top (
  // Clock, reset, enable
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // User pins as input, output and enable
  input  wire logic [`LMC_NMC-1:0]    pin_i,
  output logic      [`LMC_NMC-1:0]    pin_o,
  output logic      [`LMC_NMC-1:0]    pin_oe_o,
  output logic      [`LMC_NMC-1:0]    pin_pu_o,
  // Global clocks and programming state
  input  wire logic [`LMC_NGCLK-1:0]  gclk_i,
  input  wire logic                   in_circuit_programming_i
);

  lmc_pkg::lmc_state_t             r;
  lmc_pkg::lmc_state_t             n;
  logic [`LMC_NSYNC-1:0]           raw;
  logic [`LMC_NGCLK-1:0]           gval;
  logic [`LMC_NGCLK-1:0]           gedge;
  logic [`LMC_NMC-1:0]             mc_out;
  logic [`LMC_NMC-1:0]             mc_q;
  logic [`LMC_NMC-1:0]             mc_sexp;
  lmc_pkg::lmc_par_t [`LMC_NMC:0]  par;
  logic [`LMC_NOE-1:0]             oe_sig;
  logic [7:0]                      oe_ext;
  logic [31:0]                     rd_val;
  logic [31:0]                     status;
  logic                            req;
  logic                            prog;
  logic [1:0]                      a_mc;
  logic [2:0]                      a_pt;
  logic [2:0]                      oe_code;
  logic                            en;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign raw = {in_circuit_programming_i, gclk_i, pin_i};

  // Global clocks: optional inversion, then rising-edge detect
  // Kept outside the main process so the cells' outputs do not loop back into it
  assign gval = r.filt[`LMC_NMC +: `LMC_NGCLK] ^ r.ginv;
  assign gedge = gval & ~r.gprev;

  // The chain enters the lowest cell empty
  assign par[0] = '0;

  for (genvar i = 0; i < `LMC_NMC; i++) begin : g_mc
    lmc_macrocell u_mc (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .cfg_i    (r.mc[i]),
      .pt_i     (r.pt[i]),
      .arr_i    (r.arr),
      .gedge_i  (gedge),
      .fast_d_i (r.filt[i]),
      .par_i    (par[i]),
      .out_o    (mc_out[i]),
      .q_o      (mc_q[i]),
      .sexp_o   (mc_sexp[i]),
      .par_o    (par[i+1])
    );
  end

  always_comb begin
    n = r;

    // Three-stage capture; a change counts once stages two and three agree
    n.s1 = raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int b = 0; b < `LMC_NSYNC; b++) begin
      if (r.s2[b] == r.s3[b]) begin
        n.filt[b] = r.s3[b];
      end
    end
    prog = r.filt[`LMC_NSYNC-1];

    n.gprev = gval;

    // Feedback is registered: bypassed cells and expanders would loop otherwise
    n.arr = {mc_sexp, mc_out, r.filt[`LMC_NMC-1:0]};

    // Output enables from a pin or from a macrocell output
    for (int j = 0; j < `LMC_NOE; j++) begin
      if (r.oesel[3*j+2]) begin
        oe_sig[j] = mc_out[r.oesel[3*j +: 2]];
      end else begin
        oe_sig[j] = r.filt[r.oesel[3*j +: 2]];
      end
    end
    oe_ext = {2'h0, oe_sig};

    // I/O cells
    oe_code = 3'h0;
    en = 1'b0;
    for (int i = 0; i < `LMC_NMC; i++) begin
      oe_code = r.mc[i].oesel;
      if (oe_code == `LMC_OE_ON) begin
        en = 1'b1;
      end else if (oe_code == `LMC_OE_OFF) begin
        en = 1'b0;
      end else begin
        en = oe_ext[oe_code];
      end
      if (prog) begin
        n.pin_o[i] = 1'b0;
        n.pin_oe[i] = 1'b0;
        n.pin_pu[i] = 1'b1;
      end else if (r.mc[i].odrain) begin
        n.pin_o[i] = 1'b0;
        n.pin_oe[i] = en & ~mc_out[i];
        n.pin_pu[i] = 1'b0;
      end else begin
        n.pin_o[i] = mc_out[i];
        n.pin_oe[i] = en;
        n.pin_pu[i] = 1'b0;
      end
    end

    // Status word
    status = 32'h0;
    status[3:0] = mc_q;
    status[7:4] = r.filt[`LMC_NMC-1:0];
    status[9:8] = r.filt[`LMC_NMC +: `LMC_NGCLK];
    status[10] = prog;
    status[16:11] = oe_sig;
    status[31:26] = par[`LMC_NMC].cnt;

    // Register read mux; unmapped words read zero
    a_mc = wb_adr_i[6:5];
    a_pt = wb_adr_i[4:2];
    rd_val = 32'h0;
    if (wb_adr_i == `LMC_ADR_GCTRL) begin
      rd_val = {30'h0, r.ginv};
    end else if (wb_adr_i == `LMC_ADR_OESEL) begin
      rd_val = {14'h0, r.oesel};
    end else if (wb_adr_i == `LMC_ADR_STATUS) begin
      rd_val = status;
    end else if ({wb_adr_i[7:4], 4'h0} == `LMC_ADR_MCCFG) begin
      rd_val = r.mc[wb_adr_i[3:2]];
    end else if ({wb_adr_i[7], 7'h0} == `LMC_ADR_PTERM) begin
      if (a_pt < 3'(`LMC_NPT)) begin
        rd_val = r.pt[a_mc][a_pt];
      end
    end

    // Wishbone: answer one cycle after the request is seen, then drop
    req = wb_cyc_i & wb_stb_i & ~r.ack;
    n.ack = req;
    if (req) begin
      n.rdat = rd_val;
    end
    if (req & wb_we_i) begin
      if (wb_adr_i == `LMC_ADR_GCTRL) begin
        n.ginv = 2'(merge({30'h0, r.ginv}, wb_dat_i, wb_sel_i) & `LMC_GCTRL_WMASK);
      end else if (wb_adr_i == `LMC_ADR_OESEL) begin
        n.oesel = 18'(merge({14'h0, r.oesel}, wb_dat_i, wb_sel_i) & `LMC_OESEL_WMASK);
      end else if ({wb_adr_i[7:4], 4'h0} == `LMC_ADR_MCCFG) begin
        // Per-cell word: type, bypass, clock, speed, drive and expanders
        n.mc[wb_adr_i[3:2]] = lmc_pkg::lmc_mccfg_t'(
          merge(r.mc[wb_adr_i[3:2]], wb_dat_i, wb_sel_i) & `LMC_MCCFG_WMASK);
      end else if ({wb_adr_i[7], 7'h0} == `LMC_ADR_PTERM) begin
        if (a_pt < 3'(`LMC_NPT)) begin
          n.pt[a_mc][a_pt] = lmc_pkg::lmc_pterm_t'(
            merge(r.pt[a_mc][a_pt], wb_dat_i, wb_sel_i) & `LMC_PTERM_WMASK);
        end
      end
    end
  end

  // Clock enable low freezes bus answers too; a master must keep waiting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.ginv <= 2'(`LMC_GCTRL_RST);
      r.oesel <= 18'(`LMC_OESEL_RST);
      for (int i = 0; i < `LMC_NMC; i++) begin
        r.mc[i] <= lmc_pkg::lmc_mccfg_t'(`LMC_MCCFG_RST);
        for (int k = 0; k < `LMC_NPT; k++) begin
          r.pt[i][k] <= lmc_pkg::lmc_pterm_t'(`LMC_PTERM_RST);
        end
      end
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign pin_o = r.pin_o;
  assign pin_oe_o = r.pin_oe;
  assign pin_pu_o = r.pin_pu;

endmodule

/* File: bench/lmc_top_properties.sv */
// Port-level checks of the macrocell block.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/10ps

module lmc_top_properties (
  // Clock, reset, enable
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic [3:0]  pin_o,
  input wire logic [3:0]  pin_oe_o,
  input wire logic [3:0]  pin_pu_o,
  input wire logic        in_circuit_programming_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  // Eight samples cover the three-stage sync, filter and output register
  sequence prog_s;
    (in_circuit_programming_i && ce_i)[*8];
  endsequence
  sequence run_s;
    (!in_circuit_programming_i && ce_i)[*8];
  endsequence

  ack_answer_a: assert property (req_s |=> wb_ack_o)
    else $error("request not acked in one cycle");
  ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
    else $error("ack without request");
  prog_float_a: assert property (prog_s |-> pin_oe_o == 4'h0 && pin_pu_o == 4'hf)
    else $error("pins not floated with pull-ups while programming");
  prog_drive_a: assert property (pin_pu_o != 4'h0 |-> (pin_oe_o | pin_o) == 4'h0)
    else $error("pin driven while pulled up");
  run_no_pull_a: assert property (run_s |-> pin_pu_o == 4'h0)
    else $error("pull-up outside programming");
  reset_quiet_a: assert property ($past(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0 && pin_oe_o == 4'h0)
    else $error("outputs not quiet after reset");
  freeze_a: assert property (!ce_i |=> $stable(pin_o) && $stable(pin_oe_o) && $stable(wb_ack_o))
    else $error("state moved while enable low");
endmodule

bind lmc_top lmc_top_properties u_props (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .pin_o, .pin_oe_o, .pin_pu_o, .in_circuit_programming_i);

/* File: bench/lmc_board.sv */
// Board around the user pins: its own drivers and pull-up resistors.
// Assumes every pin has a board pull-up; contention shows as unknown.
`timescale 1ns/10ps

module lmc_board (
  // Device side
  input  wire logic [3:0] dev_o_i,
  input  wire logic [3:0] dev_oe_i,
  // Board drivers
  input  wire logic [3:0] brd_en_i,
  input  wire logic [3:0] brd_val_i,
  // Resolved wire
  output logic      [3:0] lvl_o
);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_oe_i[i] && brd_en_i[i]) begin
        lvl_o[i] = 1'bx;
      end else if (dev_oe_i[i]) begin
        lvl_o[i] = dev_o_i[i];
      end else if (brd_en_i[i]) begin
        lvl_o[i] = brd_val_i[i];
      end else begin
        lvl_o[i] = 1'b1; // Released pin rises
      end
    end
  end
endmodule

/* File: bench/tb.sv */
// Self-checking bench of the macrocell block with a board pin model.
// Assumes 125 MHz clock and bus answers within a few cycles.
`timescale 1ns/10ps
`include "lmc_defs.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end

module tb;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, prog = 0, v, w, x, d, q_m;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0, brd_val = 0, brd_en = 4'ha;
  // Capture stages, filter, array copy and output register
  localparam int pin_lat = 6;
  logic [1:0]  gclk = 0;
  logic [31:0] wdat = 0, rdat;
  wire  [31:0] dat_o;
  wire         ack_o;
  wire  [3:0]  pin_o, pin_oe, pin_pu, lvl;
  int          fails = 0, n_compared = 0, cycles = 0;
  logic [31:0] mdl [int];
  logic [7:0]  addrs [14] = '{8'h00, 8'h04, 8'h20, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h80, 8'h90, 8'h94,
                              8'hb0, 8'hb4, 8'hfc, 8'he0};
  logic [31:0] cfgs [3] = '{32'h788, 32'hf88, 32'h700};

  lmc_top u_lmc_top (.clk_i, .rst_i, .ce_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .pin_i(lvl), .pin_o(pin_o),
    .pin_oe_o(pin_oe), .pin_pu_o(pin_pu), .gclk_i(gclk), .in_circuit_programming_i(prog));
  lmc_board u_lmc_board (.dev_o_i(pin_o), .dev_oe_i(pin_oe), .brd_en_i(brd_en), .brd_val_i(brd_val),
    .lvl_o(lvl));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic print_verdict;
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Generous ceiling; the sequence needs about 1400 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  function automatic logic [31:0] wmask(int a);
    if (a == 0) return 32'h3;
    if (a == 4) return 32'h3ffff;
    if (a >= 8'h40 && a <= 8'h4c) return 32'h3fff;
    if (a >= 8'h80 && (a - 8'h80) % 32 < 20) return 32'h07ffffff;
    return 32'h0;
  endfunction

  function automatic logic [31:0] ex(int a);
    return mdl.exists(a) ? mdl[a] : 32'h0;
  endfunction

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    rdat = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 40) fails++;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & wmask(a);
    if (wmask(a) != 0) mdl[a] = (ex(a) & ~m) | (d & m);
    wb(1'b1, a, d, s);
  endtask

  initial begin
    void'($urandom(32'hbdb6a373));
    mdl[0] = `LMC_GCTRL_RST;
    mdl[4] = `LMC_OESEL_RST;
    for (int m = 0; m < 4; m++) begin
      mdl[64 + 4 * m] = `LMC_MCCFG_RST;
      for (int k = 0; k < 5; k++) mdl[128 + 32 * m + 4 * k] = `LMC_PTERM_RST;
    end
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    foreach (addrs[i]) begin
      wb(1'b0, addrs[i], 32'h0, 4'h0);
      `CHK("reset_value", ex(addrs[i]), rdat)
      wr(addrs[i], $urandom, 4'($urandom));
      wb(1'b0, addrs[i], 32'h0, 4'h0);
      `CHK("readback", ex(addrs[i]), rdat)
    end
    wr(8'h08, 32'hffffffff, 4'hf);
    // Idle with enable low so nothing may move
    ce_i <= 0;
    repeat (4) @(posedge clk_i);
    ce_i <= 1;
    wr(8'h00, 32'h0, 4'hf);
    for (int m = 0; m < 4; m++) begin
      wr(8'(64 + 4 * m), `LMC_MCCFG_RST, 4'hf);
      for (int k = 0; k < 5; k++) wr(8'(128 + 32 * m + 4 * k), `LMC_PTERM_RST, 4'hf);
    end
    wr(8'h80, 32'h2, 4'hf); // OR term on pin 1
    foreach (cfgs[c]) begin
      wr(8'h40, cfgs[c], 4'hf);
      repeat (4) begin
        v = 1'($urandom);
        brd_val <= {2'b00, v, 1'b0};
        repeat (12) @(posedge clk_i);
        gclk <= 2'b01;
        repeat (6) @(posedge clk_i);
        gclk <= 2'b00;
        repeat (6) @(posedge clk_i);
        `CHK("pin_o", (c == 1) ? 1'b0 : v, pin_o[0])
        `CHK("pin_oe", (c == 0) ? 1'b1 : (c == 1) ? ~v : 1'b0, pin_oe[0])
        `CHK("pin_level", (c == 2) ? 1'b1 : v, lvl[0])
        wb(1'b0, 8'h08, 32'h0, 4'h0);
        `CHK("reg_q", v, rdat[0])
        brd_val <= {2'b00, ~v, 1'b0};
        repeat (12) @(posedge clk_i);
        wb(1'b0, 8'h08, 32'h0, 4'h0);
        `CHK("reg_hold", v, rdat[0])
      end
    end
    // Register types against a reference: J or S from pin 1, K or R from pin 3
    wr(8'h84, 32'h0600_0008, 4'hf);
    q_m = 0;
    for (int t = 0; t < 4; t++) begin
      x = 1'($urandom);
      wr(8'h40, 32'h700 | (32'(x) << 2) | 32'(t), 4'hf);
      repeat (4) begin
        v = 1'($urandom);
        w = 1'($urandom);
        brd_val <= {w, 1'b0, v, 1'b0};
        repeat (12) @(posedge clk_i);
        gclk <= 2'b01;
        repeat (6) @(posedge clk_i);
        gclk <= 2'b00;
        repeat (6) @(posedge clk_i);
        d = v ^ x;
        case (t)
          0: q_m = d;
          1: q_m = q_m ^ d;
          2: q_m = (d & ~q_m) | (~w & q_m);
          default: q_m = d | (~w & q_m);
        endcase
        wb(1'b0, 8'h08, 32'h0, 4'h0);
        `CHK("ff_type", q_m, rdat[0])
      end
    end
    // Pin to output latency, low power first, then high speed
    for (int h = 0; h < 2; h++) begin
      wr(8'h40, (h == 1) ? 32'h788 : 32'h388, 4'hf);
      brd_val <= 4'h0;
      repeat (12) @(posedge clk_i);
      brd_val <= 4'h2;
      repeat (pin_lat - 1 + ((h == 1) ? 0 : `LMC_LPA_CYC)) @(posedge clk_i);
      @(negedge clk_i);
      `CHK("lat_early", 1'b0, pin_o[0])
      @(negedge clk_i);
      `CHK("lat_due", 1'b1, pin_o[0])
      @(posedge clk_i);
    end
    // Preset then clear from a pin 3 term, with no clock edge at all
    wr(8'h40, 32'h700, 4'hf);
    brd_val <= 4'h8;
    wr(8'h84, 32'h0200_0008, 4'hf);
    repeat (8) @(posedge clk_i);
    wb(1'b0, 8'h08, 32'h0, 4'h0);
    `CHK("preset", 1'b1, rdat[0])
    wr(8'h84, 32'h0100_0008, 4'hf);
    repeat (8) @(posedge clk_i);
    wb(1'b0, 8'h08, 32'h0, 4'h0);
    `CHK("clear", 1'b0, rdat[0])
    // Fast path: pin 0 straight into the register while pin 1 drives the sum
    wr(8'h84, `LMC_PTERM_RST, 4'hf);
    wr(8'h40, 32'h710, 4'hf);
    brd_en <= 4'hb;
    repeat (2) begin
      v = 1'($urandom);
      brd_val <= {2'b00, ~v, v};
      repeat (12) @(posedge clk_i);
      gclk <= 2'b01;
      repeat (6) @(posedge clk_i);
      gclk <= 2'b00;
      repeat (6) @(posedge clk_i);
      wb(1'b0, 8'h08, 32'h0, 4'h0);
      `CHK("fast_path", v, rdat[0])
    end
    // Output enable 0 taken from pin 1
    brd_en <= 4'ha;
    wr(8'h04, 32'h1, 4'hf);
    wr(8'h40, 32'h408, 4'hf);
    repeat (2) begin
      v = 1'($urandom);
      brd_val <= {2'b00, v, 1'b0};
      repeat (12) @(posedge clk_i);
      `CHK("oe_from_pin", v, pin_oe[0])
    end
    prog <= 1;
    repeat (12) @(posedge clk_i);
    `CHK("pin_pu", 4'hf, pin_pu)
    `CHK("pin_oe_all", 4'h0, pin_oe)
    wb(1'b0, 8'h08, 32'h0, 4'h0);
    `CHK("prog_flag", 1'b1, rdat[10])
    prog <= 0;
    repeat (12) @(posedge clk_i);
    `CHK("pin_pu_off", 4'h0, pin_pu)
    print_verdict();
  end
endmodule
